/* File: core/ebfe_map.svh */
/*
  Register offsets, field positions, reset values and depths of the
  external bus front end. Assumes a 32-bit APB with byte addressing.
*/
`ifndef EBFE_MAP_SVH
`define EBFE_MAP_SVH
// Register byte offsets
`define EBFE_MODE_OFS 12'h000
`define EBFE_MCFG_OFS 12'h004
`define EBFE_DIV_OFS 12'h008
`define EBFE_MAP_OFS 12'h00c
`define EBFE_RADDR_OFS 12'h010
`define EBFE_RSIZE_OFS 12'h014
`define EBFE_RCNT_OFS 12'h018
`define EBFE_RSTOP_OFS 12'h01c
`define EBFE_RAVAIL_OFS 12'h020
`define EBFE_RDATA_OFS 12'h024
`define EBFE_FCFG_OFS 12'h028
`define EBFE_WFREE_OFS 12'h02c
`define EBFE_IM_OFS 12'h030
`define EBFE_RIS_OFS 12'h034
`define EBFE_MIS_OFS 12'h038
`define EBFE_EISC_OFS 12'h03c
// Address map fields
`define EBFE_PSIZE 1:0
`define EBFE_PBASE 3:2
`define EBFE_RSIZE 5:4
`define EBFE_RBASE 7:6
`define EBFE_QUAD 8
`define EBFE_CSIZE 10:9
`define EBFE_CBASE 11
// Fifo config fields
`define EBFE_RTRIG 3:0
`define EBFE_WTRIG 6:4
`define EBFE_WERR_EN 8
`define EBFE_RERR_EN 9
// Window base nibbles
`define EBFE_NIB_CODE 4'h1
`define EBFE_NIB_6 4'h6
`define EBFE_NIB_8 4'h8
`define EBFE_NIB_A 4'ha
`define EBFE_NIB_C 4'hc
// Depths and reset values
`define EBFE_WQ_DEPTH 3'h4
`define EBFE_RQ_DEPTH 4'h8
`define EBFE_DIV_RST 16'h0001
`endif

/* File: core/ebfe_pkg.sv */
/*
  Types of the external bus front end. Assumes ebfe_map.svh for numbers.
*/
package ebfe_pkg;
  // Operating modes of the external pins
  typedef enum logic [1:0] {EBFE_SDRAM, EBFE_HB8, EBFE_HB16, EBFE_GP} ebfe_mode_t;
  // Transaction engine states
  typedef enum logic [1:0] {EBFE_IDLE, EBFE_WR, EBFE_SRD, EBFE_BRD} ebfe_state_t;
endpackage

/* File: core/ebfe_rq.sv */
/*
  Read queue of the external bus front end: eight 32-bit items.
  Assumes the caller never pushes when full nor pops when empty.
*/
`timescale 1ns/1ps
`include "ebfe_map.svh"
module ebfe_rq
  import ebfe_pkg::*;
(
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic push, // Store one item
  input wire logic [31:0] wdata, // Item to store
  input wire logic pop, // Remove oldest item
  output logic [31:0] rdata, // Oldest item
  output logic [3:0] count // Items held
);
  logic [31:0] mem [0:7]; // Storage
  logic [2:0] wptr; // Write pointer
  logic [2:0] rptr; // Read pointer

  // Pointers and fill count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wptr <= 3'h0;
      rptr <= 3'h0;
      count <= 4'h0;
    end
    else
    begin
      wptr <= wptr + {2'h0, push};
      rptr <= rptr + {2'h0, pop};
      count <= count + {3'h0, push} - {3'h0, pop};
    end
  end

  // Storage has no reset; empty slots are never read
  always_ff @(posedge pclk)
  begin
    if (push)
      mem[wptr] <= wdata;
  end

  assign rdata = mem[rptr];
endmodule

/* File: core/ebfe_top.sv */
/*
  External bus front end: APB registers, window decode, write queue,
  background read engine and interrupt status.
  Assumes the external pin sequencer answers each request with ext_done.
*/
`timescale 1ns/1ps
`include "ebfe_map.svh"
module ebfe_top
  import ebfe_pkg::*;
(
  input wire logic pclk, // System clock, 125 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic sys_valid, // Processor bus request
  input wire logic sys_write, // Processor write
  input wire logic [31:0] sys_addr, // Processor address
  input wire logic [31:0] sys_wdata, // Processor write data
  input wire logic [1:0] sys_size, // 0 byte, 1 half, 2 word
  output logic sys_ready, // Request taken or answered
  output logic sys_err, // Unmapped address
  output logic [31:0] sys_rdata, // Processor read data
  output logic ext_tick, // Divided external bus clock pulse
  output logic ext_req, // External transaction request
  output logic ext_write, // External direction
  output logic [27:0] ext_addr, // Offset inside window
  output logic [3:0] ext_cs_n, // Chip selects, active low
  output logic [1:0] ext_size, // Transfer size
  output logic [31:0] ext_wdata, // External write data
  input wire logic ext_done, // Transaction finished
  input wire logic [31:0] ext_rdata, // External read data
  output ebfe_mode_t mode, // Selected pin protocol
  output logic [31:0] mode_cfg, // Mode configuration word
  output logic dma_rd_req, // Read queue DMA request
  output logic dma_wr_req, // Write queue DMA request
  output logic irq // Interrupt, active high
);
  // Byte mask of a window from its size select
  function automatic logic [27:0] win_mask(input logic [1:0] sz);
    case (sz)
      2'h0: win_mask = 28'h00000ff;
      2'h1: win_mask = 28'h000ffff;
      2'h2: win_mask = 28'h0ffffff;
      default: win_mask = 28'hfffffff;
    endcase
  endfunction

  // Address falls in the window at a base nibble
  function automatic logic win_hit(input logic [31:0] a, input logic [3:0] nib,
    input logic [1:0] sz);
    win_hit = (a[31:28] == nib) && ((a[27:0] & ~win_mask(sz)) == 28'h0);
  endfunction

  logic [15:0] div; // Clock divider
  logic [15:0] divcnt; // Divider counter
  logic [11:0] amap; // Address map
  logic [27:0] raddr; // Background read start
  logic [1:0] rsize; // Background read item size
  logic [27:0] bcur; // Background read next address
  logic [15:0] remain; // Items still to fetch
  logic [9:0] fcfg; // Trigger levels and error enables
  logic [2:0] im; // Interrupt enables
  logic [1:0] eisc; // Error causes: write stall, read stall
  ebfe_state_t state; // Engine state
  logic sr_done; // Processor read answered
  logic ack; // APB answer pending
  logic [27:0] wq_addr [0:3]; // Write queue addresses
  logic [31:0] wq_data [0:3]; // Write queue data
  logic [1:0] wq_size [0:3]; // Write queue sizes
  logic [1:0] wq_cs [0:3]; // Write queue chip selects
  logic [1:0] wq_wp; // Write queue write pointer
  logic [1:0] wq_rp; // Write queue read pointer
  logic [2:0] wq_cnt; // Writes held
  logic map_hit; // Decoded window hit
  logic [1:0] map_cs; // Decoded chip select
  logic [27:0] map_off; // Decoded offset
  logic wq_push; // Accept processor write
  logic wq_pop; // External write finished
  logic rq_push; // Background item arrives
  logic rq_pop; // Software pops an item
  logic [31:0] rq_data; // Oldest read queue item
  logic [3:0] rq_cnt; // Read queue fill
  logic [2:0] ris; // Raw interrupt status
  logic apb_rd; // APB read in access phase
  logic apb_wr; // APB write completes
  logic rq_stall; // Pop waits on empty queue
  logic launch_ok; // Engine may start a transaction
  logic [31:0] rdmux; // Register read value

  // Window decode, quad mode takes precedence over single windows
  always_comb
  begin
    map_hit = 1'b0;
    map_cs = 2'h0;
    map_off = sys_addr[27:0] & win_mask(amap[`EBFE_RSIZE]);
    if (amap[`EBFE_QUAD])
    begin
      map_hit = win_hit(sys_addr, `EBFE_NIB_6, amap[`EBFE_RSIZE])
        || win_hit(sys_addr, `EBFE_NIB_8, amap[`EBFE_RSIZE])
        || win_hit(sys_addr, `EBFE_NIB_A, amap[`EBFE_RSIZE])
        || win_hit(sys_addr, `EBFE_NIB_C, amap[`EBFE_RSIZE]);
      map_cs = sys_addr[30:29] - 2'h3; // 6->0, 8->1, a->2, c->3
    end
    else if ((amap[`EBFE_RBASE] == 2'h1 && win_hit(sys_addr, `EBFE_NIB_6,
      amap[`EBFE_RSIZE])) || (amap[`EBFE_RBASE] == 2'h2 &&
      win_hit(sys_addr, `EBFE_NIB_8, amap[`EBFE_RSIZE])))
      map_hit = 1'b1;
    else if ((amap[`EBFE_PBASE] == 2'h1 && win_hit(sys_addr, `EBFE_NIB_A,
      amap[`EBFE_PSIZE])) || (amap[`EBFE_PBASE] == 2'h2 &&
      win_hit(sys_addr, `EBFE_NIB_C, amap[`EBFE_PSIZE])))
    begin
      map_hit = 1'b1;
      map_cs = 2'h1;
      map_off = sys_addr[27:0] & win_mask(amap[`EBFE_PSIZE]);
    end
    else if (amap[`EBFE_CBASE] && win_hit(sys_addr, `EBFE_NIB_CODE,
      amap[`EBFE_CSIZE]))
    begin
      map_hit = 1'b1;
      map_off = sys_addr[27:0] & win_mask(amap[`EBFE_CSIZE]);
    end
  end

  // Processor handshake: writes queue, reads wait for the engine
  assign wq_push = sys_valid && sys_write && map_hit && (wq_cnt < `EBFE_WQ_DEPTH);
  assign sys_err = sys_valid && !map_hit;
  assign sys_ready = wq_push || sys_err || (sys_valid && !sys_write && sr_done);
  assign wq_pop = (state == EBFE_WR) && ext_done;
  assign rq_push = (state == EBFE_BRD) && ext_done;

  // External bus rate pulse from the divider
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      divcnt <= 16'h0;
    else if (divcnt >= div)
      divcnt <= 16'h0;
    else
      divcnt <= divcnt + 16'h1;
  end
  assign ext_tick = (divcnt == div);
  assign launch_ok = ext_tick && (state == EBFE_IDLE);

  // Write queue storage; sized to hold four pending writes
  always_ff @(posedge pclk)
  begin
    if (wq_push)
    begin
      wq_addr[wq_wp] <= map_off;
      wq_data[wq_wp] <= sys_wdata;
      wq_size[wq_wp] <= sys_size;
      wq_cs[wq_wp] <= map_cs;
    end
  end

  // Write queue pointers and fill
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wq_wp <= 2'h0;
      wq_rp <= 2'h0;
      wq_cnt <= 3'h0;
    end
    else
    begin
      wq_wp <= wq_wp + {1'b0, wq_push};
      wq_rp <= wq_rp + {1'b0, wq_pop};
      wq_cnt <= wq_cnt + {2'h0, wq_push} - {2'h0, wq_pop};
    end
  end

  // Engine: queued writes first, then processor read, then background read;
  // a processor read waits for the queue to drain so ordering is kept
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= EBFE_IDLE;
      ext_req <= 1'b0;
      ext_write <= 1'b0;
      ext_addr <= 28'h0;
      ext_cs_n <= 4'hf;
      ext_size <= 2'h0;
      ext_wdata <= 32'h0;
    end
    else
    case (state)
      EBFE_IDLE:
      begin
        if (launch_ok && wq_cnt != 3'h0)
        begin
          state <= EBFE_WR;
          ext_req <= 1'b1;
          ext_write <= 1'b1;
          ext_addr <= wq_addr[wq_rp];
          ext_cs_n <= ~(4'h1 << wq_cs[wq_rp]);
          ext_size <= wq_size[wq_rp];
          ext_wdata <= wq_data[wq_rp];
        end
        else if (launch_ok && sys_valid && !sys_write && map_hit && !sr_done)
        begin
          state <= EBFE_SRD;
          ext_req <= 1'b1;
          ext_write <= 1'b0;
          ext_addr <= map_off;
          ext_cs_n <= ~(4'h1 << map_cs);
          ext_size <= sys_size;
        end
        else if (launch_ok && remain != 16'h0 && rq_cnt < `EBFE_RQ_DEPTH)
        begin
          state <= EBFE_BRD;
          ext_req <= 1'b1;
          ext_write <= 1'b0;
          ext_addr <= bcur;
          ext_cs_n <= 4'he;
          ext_size <= rsize;
        end
      end
      default:
      begin
        if (ext_done)
        begin
          state <= EBFE_IDLE;
          ext_req <= 1'b0;
          ext_cs_n <= 4'hf;
        end
      end
    endcase
  end

  // Processor read answer held until the processor takes it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sr_done <= 1'b0;
      sys_rdata <= 32'h0;
    end
    else if (state == EBFE_SRD && ext_done)
    begin
      sr_done <= 1'b1;
      sys_rdata <= ext_rdata;
    end
    else if (sys_valid && !sys_write && sr_done)
      sr_done <= 1'b0;
  end

  // Background channel: start loads count, stop clears it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      remain <= 16'h0;
      bcur <= 28'h0;
    end
    else if (apb_wr && paddr == `EBFE_RCNT_OFS)
    begin
      remain <= pwdata[15:0];
      bcur <= raddr;
    end
    else if (apb_wr && paddr == `EBFE_RSTOP_OFS)
      remain <= 16'h0;
    else if (rq_push && remain != 16'h0)
    begin
      remain <= remain - 16'h1;
      bcur <= bcur + (28'h1 << rsize);
    end
  end

  ebfe_rq u_rq
  (
    .pclk(pclk),
    .presetn(presetn),
    .push(rq_push),
    .wdata(ext_rdata),
    .pop(rq_pop),
    .rdata(rq_data),
    .count(rq_cnt)
  );

  // APB: answer one cycle into the access phase; a pop of an empty
  // queue stretches the access until an item lands
  assign apb_rd = psel && penable && !pwrite && !ack;
  assign rq_stall = apb_rd && paddr == `EBFE_RDATA_OFS && rq_cnt == 4'h0;
  assign rq_pop = apb_rd && paddr == `EBFE_RDATA_OFS && rq_cnt != 4'h0;
  assign apb_wr = psel && penable && pwrite && ack;
  assign pready = ack;

  // Register read view
  always_comb
  begin
    rdmux = 32'h0;
    case (paddr)
      `EBFE_MODE_OFS: rdmux = {30'h0, mode};
      `EBFE_MCFG_OFS: rdmux = mode_cfg;
      `EBFE_DIV_OFS: rdmux = {16'h0, div};
      `EBFE_MAP_OFS: rdmux = {20'h0, amap};
      `EBFE_RADDR_OFS: rdmux = {4'h0, raddr};
      `EBFE_RSIZE_OFS: rdmux = {30'h0, rsize};
      `EBFE_RCNT_OFS: rdmux = {16'h0, remain};
      `EBFE_RAVAIL_OFS: rdmux = {28'h0, rq_cnt};
      `EBFE_RDATA_OFS:
      case (rsize)
        2'h0: rdmux = {24'h0, rq_data[7:0]};
        2'h1: rdmux = {16'h0, rq_data[15:0]};
        default: rdmux = rq_data;
      endcase
      `EBFE_FCFG_OFS: rdmux = {22'h0, fcfg};
      `EBFE_WFREE_OFS: rdmux = {29'h0, `EBFE_WQ_DEPTH - wq_cnt};
      `EBFE_IM_OFS: rdmux = {29'h0, im};
      `EBFE_RIS_OFS: rdmux = {29'h0, ris};
      `EBFE_MIS_OFS: rdmux = {29'h0, ris & im};
      `EBFE_EISC_OFS: rdmux = {30'h0, eisc};
      default: rdmux = 32'h0;
    endcase
  end

  // APB answer flop and registered read data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
    else if (psel && penable && !ack && !rq_stall)
    begin
      ack <= 1'b1;
      prdata <= pwrite ? 32'h0 : rdmux;
      pslverr <= paddr[11:6] != 6'h0 || paddr[1:0] != 2'h0;
    end
    else
    begin
      ack <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Configuration registers, written at the completing edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode <= EBFE_SDRAM;
      mode_cfg <= 32'h0;
      div <= `EBFE_DIV_RST;
      amap <= 12'h0;
      raddr <= 28'h0;
      rsize <= 2'h2;
      fcfg <= 10'h0;
      im <= 3'h0;
    end
    else if (apb_wr)
    case (paddr)
      `EBFE_MODE_OFS: mode <= ebfe_mode_t'(pwdata[1:0]);
      `EBFE_MCFG_OFS: mode_cfg <= pwdata;
      `EBFE_DIV_OFS: div <= pwdata[15:0];
      `EBFE_MAP_OFS: amap <= pwdata[11:0];
      `EBFE_RADDR_OFS: raddr <= pwdata[27:0];
      `EBFE_RSIZE_OFS: rsize <= pwdata[1:0];
      `EBFE_FCFG_OFS: fcfg <= pwdata[9:0];
      `EBFE_IM_OFS: im <= pwdata[2:0];
      default: mode <= mode;
    endcase
  end

  // Error causes: set wins over a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      eisc <= 2'h0;
    else
      eisc <= (eisc & ~((apb_wr && paddr == `EBFE_EISC_OFS) ? pwdata[1:0] : 2'h0))
        | {fcfg[`EBFE_RERR_EN] && rq_stall,
           fcfg[`EBFE_WERR_EN] && sys_valid && sys_write && map_hit && !wq_push};
  end

  // Queue level requests; a zero trigger turns a request off
  assign ris[0] = fcfg[`EBFE_RTRIG] != 4'h0 && rq_cnt >= fcfg[`EBFE_RTRIG];
  assign ris[1] = fcfg[`EBFE_WTRIG] != 3'h0
    && (`EBFE_WQ_DEPTH - wq_cnt) >= fcfg[`EBFE_WTRIG];
  assign ris[2] = eisc != 2'h0;
  assign dma_rd_req = ris[0];
  assign dma_wr_req = ris[1];
  assign irq = (ris & im) != 3'h0;

  // Queue never holds more than its depth
  a_wq_bound: assert property (@(posedge pclk) disable iff (!presetn)
    wq_cnt <= `EBFE_WQ_DEPTH) else $error("write queue overfilled");
  // Only mapped writes stall; an unmapped one is refused at once even when full
  a_wq_stall: assert property (@(posedge pclk) disable iff (!presetn)
    (wq_cnt == 3'h4 && sys_valid && sys_write && map_hit) |-> !sys_ready)
    else $error("full queue accepted a write");
  a_tick_gap: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(ext_req)) |-> $past(ext_tick)) else $error("launch off tick");
  a_remain_dec: assert property (@(posedge pclk) disable iff (!presetn)
    (rq_push && remain != 16'h0 && !apb_wr) |=> remain == $past(remain) - 16'h1)
    else $error("remaining count not decremented");
  a_stop_clr: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_wr && paddr == `EBFE_RSTOP_OFS) |=> remain == 16'h0)
    else $error("stop did not halt channel");
  a_err_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (fcfg[`EBFE_RERR_EN] && rq_stall) |=> eisc[1]) else $error("read stall lost");
  // Masked status read back is the raw status under the enables of that cycle
  a_mis_read: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pwrite && !ack && paddr == `EBFE_MIS_OFS)
    |=> prdata == {29'h0, $past(ris & im)})
    else $error("masked status wrong");
  a_quad_cs: assert property (@(posedge pclk) disable iff (!presetn)
    (amap[`EBFE_QUAD] && sys_addr[31:28] == 4'hc && map_hit) |-> map_cs == 2'h3)
    else $error("quad select wrong");
  a_pop_wait: assert property (@(posedge pclk) disable iff (!presetn)
    rq_stall |=> !pready) else $error("empty pop answered");
endmodule

/* File: verif/ebfe_ext_model.sv */
/*
  Model of the external pin sequencer with its memory behind it.
  Assumes ebfe_top holds ext_req and the request fields until ext_done.
*/
`timescale 1ns/1ps
module ebfe_ext_model (
  input wire logic pclk, // System clock
  input wire logic presetn, // Reset, active low
  input wire logic ext_req, // Request level
  input wire logic [27:0] ext_addr, // Window offset
  input wire logic [7:0] dly, // Answer delay in cycles
  output logic ext_done, // One-cycle completion
  output logic [31:0] ext_rdata, // Read data
  output logic [15:0] n_done // Completions so far
);
  logic [7:0] cnt; // Wait counter
  // Answer after dly cycles; gap cycle after done keeps one answer per request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_done <= 1'b0;
      cnt <= 8'h00;
      n_done <= 16'h0000;
    end
    else if (ext_done)
    begin
      ext_done <= 1'b0;
      cnt <= 8'h00;
    end
    else if (ext_req && cnt == dly)
    begin
      ext_done <= 1'b1;
      n_done <= n_done + 16'h0001;
    end
    else if (ext_req)
      cnt <= cnt + 8'h01;
  end
  // Data follows the address; outside done it flips so stale data never matches
  always_ff @(posedge pclk)
  begin
    if (ext_req && !ext_done && cnt == dly)
      ext_rdata <= {4'h5, ext_addr};
    else
      ext_rdata <= ~ext_rdata;
  end
endmodule

/* File: verif/ebfe_top_tb.sv */
/*
  Self-checking bench of ebfe_top: APB master, processor bus driver,
  external model. Assumes the register map of ebfe_map.svh.
*/
`timescale 1ns/1ps
`include "ebfe_map.svh"
module ebfe_top_tb;
  import ebfe_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, sys_addr = 0, sys_wdata = 0, sys_rdata, ext_wdata, ext_rdata;
  logic pready, pslverr, sys_valid = 0, sys_write = 0, sys_ready, sys_err, ext_tick;
  logic ext_req, ext_write, ext_done, dma_rd_req, dma_wr_req, irq;
  logic [27:0] ext_addr, cap_addr;
  logic [3:0] ext_cs_n, cap_cs;
  logic [1:0] ext_size;
  logic [31:0] mode_cfg, q, srd, cap_data;
  ebfe_mode_t mode;
  logic [7:0] dly = 8'h02; // Model answer delay
  logic [15:0] n_done;
  logic serr, slv, cap_wr;
  logic [1:0] sys_size = 2'h2, cap_size; // Request size and captured external size
  int fail_count = 0, num_checks = 0;
  // Free-running 125 MHz system clock
  initial
  begin
    forever #4 pclk = ~pclk;
  end
  ebfe_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sys_valid(sys_valid), .sys_write(sys_write), .sys_addr(sys_addr),
    .sys_wdata(sys_wdata), .sys_size(sys_size), .sys_ready(sys_ready), .sys_err(sys_err),
    .sys_rdata(sys_rdata), .ext_tick(ext_tick), .ext_req(ext_req), .ext_write(ext_write),
    .ext_addr(ext_addr), .ext_cs_n(ext_cs_n), .ext_size(ext_size), .ext_wdata(ext_wdata),
    .ext_done(ext_done), .ext_rdata(ext_rdata), .mode(mode), .mode_cfg(mode_cfg),
    .dma_rd_req(dma_rd_req), .dma_wr_req(dma_wr_req), .irq(irq));
  ebfe_ext_model ext (.pclk(pclk), .presetn(presetn), .ext_req(ext_req),
    .ext_addr(ext_addr), .dly(dly), .ext_done(ext_done), .ext_rdata(ext_rdata),
    .n_done(n_done));
  // Snapshot of each finished external transaction
  always @(posedge pclk)
  begin
    if (ext_done)
    begin
      cap_addr <= ext_addr;
      cap_cs <= ext_cs_n;
      cap_wr <= ext_write;
      cap_data <= ext_wdata;
      cap_size <= ext_size;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 2000);
    if (pready !== 1'b1)
      fail_count++;
    q = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  // Processor request held until sys_ready; st counts the cycles it took
  task automatic sysop(input logic w, input logic [31:0] a, output int st);
    @(posedge pclk);
    sys_valid <= 1'b1;
    sys_write <= w;
    sys_addr <= a;
    sys_wdata <= ~a;
    st = 0;
    do
    begin
      @(posedge pclk);
      st++;
    end
    while (sys_ready !== 1'b1 && st < 2000);
    if (sys_ready !== 1'b1)
      fail_count++;
    serr = sys_err;
    srd = sys_rdata;
    sys_valid <= 1'b0;
  endtask
  task automatic wdone(input logic [15:0] t);
    int n;
    n = 0;
    while (n_done < t && n < 3000)
    begin
      @(posedge pclk);
      n++;
    end
    if (n_done < t)
      fail_count++;
  endtask
  task automatic t_reset;
    rc(`EBFE_DIV_OFS, 32'h1);
    rc(`EBFE_WFREE_OFS, 32'h4);
    rc(`EBFE_RAVAIL_OFS, 32'h0);
    rc(12'h040, 32'h0);
    chk(slv, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_mode;
    int n;
    for (int m = 0; m < 4; m++)
    begin
      apb(1'b1, `EBFE_MODE_OFS, m);
      apb(1'b1, `EBFE_MCFG_OFS, 32'ha500_0000 | m);
      // The write lands at the edge that ends the task; look once it has settled
      @(negedge pclk);
      chk(mode, m);
      chk(mode_cfg, 32'ha500_0000 | m);
    end
    apb(1'b1, `EBFE_DIV_OFS, 32'h3);
    n = 0;
    repeat (40)
    begin
      @(posedge pclk);
      n += ext_tick;
    end
    chk(n, 10);
    $display("test mode and divider done");
  endtask
  // Window decode: RAM at 6 (64K), peripheral at A (256B), code at 1 (256B)
  task automatic t_map;
    logic [31:0] ad[6] = '{32'h6000_1234, 32'h6001_0000, 32'ha000_0010, 32'ha000_0100,
      32'h1000_0020, 32'h7000_0000};
    logic [3:0] cs[6] = '{4'he, 4'hf, 4'hd, 4'hf, 4'he, 4'hf};
    logic [3:0] nib[4] = '{`EBFE_NIB_6, `EBFE_NIB_8, `EBFE_NIB_A, `EBFE_NIB_C};
    int st;
    apb(1'b1, `EBFE_MAP_OFS, 32'h854);
    for (int i = 0; i < 6; i++)
    begin
      sysop(1'b1, ad[i], st);
      chk(serr, cs[i] == 4'hf);
      if (cs[i] != 4'hf)
      begin
        wdone(n_done + 16'h1);
        @(posedge pclk);
        chk({cap_cs, cap_addr}, {cs[i], 28'h0 | ad[i][15:0]});
        chk(cap_wr, 1'b1);
        chk(cap_data, ~ad[i]);
      end
    end
    sysop(1'b0, 32'h6000_0004, st);
    chk(srd, {4'h5, 28'h4});
    apb(1'b1, `EBFE_MAP_OFS, 32'h100);
    sys_size <= 2'h0;
    for (int i = 0; i < 4; i++)
    begin
      sysop(1'b1, {nib[i], 28'h8}, st);
      wdone(n_done + 16'h1);
      @(posedge pclk);
      chk({cap_size, cap_cs}, {2'h0, ~(4'h1 << i)});
    end
    sys_size <= 2'h2;
    $display("test map done");
  endtask
  // Slow far side: queue fills, stalls, raises the write error
  task automatic t_wq;
    int st, mx;
    logic [15:0] n0;
    apb(1'b1, `EBFE_MAP_OFS, 32'h50);
    apb(1'b1, `EBFE_FCFG_OFS, 32'h140);
    apb(1'b1, `EBFE_IM_OFS, 32'h4);
    dly <= 8'h3c;
    n0 = n_done;
    mx = 0;
    for (int i = 0; i < 6; i++)
    begin
      sysop(1'b1, 32'h6000_0100 + 4 * i, st);
      mx = (st > mx) ? st : mx;
    end
    chk(mx > 4, 1'b1);
    chk(dma_wr_req, 1'b0);
    rc(`EBFE_WFREE_OFS, 32'h0);
    rc(`EBFE_EISC_OFS, 32'h1);
    rc(`EBFE_RIS_OFS, 32'h4);
    rc(`EBFE_MIS_OFS, 32'h4);
    chk(irq, 1'b1);
    apb(1'b1, `EBFE_EISC_OFS, 32'h1);
    rc(`EBFE_EISC_OFS, 32'h0);
    chk(irq, 1'b0);
    wdone(n0 + 16'h6);
    rc(`EBFE_WFREE_OFS, 32'h4);
    chk(dma_wr_req, 1'b1);
    $display("test write queue done");
  endtask
  // Background reads at each item size, then a stop in mid-run
  task automatic t_bg;
    logic [31:0] m;
    int n;
    dly <= 8'h02;
    apb(1'b1, `EBFE_FCFG_OFS, 32'h3);
    apb(1'b1, `EBFE_IM_OFS, 32'h1);
    for (int s = 2; s >= 0; s--)
    begin
      m = (s == 2) ? 32'hffff_ffff : (s == 1) ? 32'hffff : 32'hff;
      apb(1'b1, `EBFE_RSIZE_OFS, s);
      apb(1'b1, `EBFE_RADDR_OFS, 32'h140);
      apb(1'b1, `EBFE_RCNT_OFS, 32'h3);
      n = 0;
      do
      begin
        apb(1'b0, `EBFE_RAVAIL_OFS, 32'h0);
        n++;
      end
      while (q !== 32'h3 && n < 100);
      chk(q, 32'h3);
      rc(`EBFE_RCNT_OFS, 32'h0);
      chk({dma_rd_req, irq}, 2'h3);
      for (int i = 0; i < 3; i++)
        rc(`EBFE_RDATA_OFS, {4'h5, 28'h140 + 28'(i << s)} & m);
    end
    apb(1'b1, `EBFE_RSIZE_OFS, 32'h2);
    apb(1'b1, `EBFE_FCFG_OFS, 32'h203);
    dly <= 8'h28;
    apb(1'b1, `EBFE_RCNT_OFS, 32'h8);
    // Pop before the first item lands: the access stalls and flags the cause
    rc(`EBFE_RDATA_OFS, 32'h5000_0140);
    rc(`EBFE_EISC_OFS, 32'h2);
    apb(1'b1, `EBFE_EISC_OFS, 32'h2);
    rc(`EBFE_EISC_OFS, 32'h0);
    repeat (60) @(posedge pclk);
    apb(1'b1, `EBFE_RSTOP_OFS, 32'h1);
    repeat (400) @(posedge pclk);
    apb(1'b0, `EBFE_RAVAIL_OFS, 32'h0);
    chk(q > 0 && q < 4, 1'b1);
    for (int i = q; i > 0; i--)
      apb(1'b0, `EBFE_RDATA_OFS, 32'h0);
    $display("test background read done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog well beyond the expected run length
  initial
  begin
    #800000;
    fail_count++;
    end_of_test();
  end
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_mode();
    t_map();
    t_wq();
    t_bg();
    end_of_test();
  end
endmodule
